// ===== verilog/sadc_defines.svh
// shared constants of the converter control and serial readout pair
// assumes a 200 MHz system clock on both ends
`ifndef SADC_DEFINES_SVH
`define SADC_DEFINES_SVH

// =====================================================
// result and timing
`define SADC_RES_W 20
`define SADC_CLK_NS 5
`define SADC_POR_NS 200000
`define SADC_POR_CYC ((`SADC_POR_NS + `SADC_CLK_NS - 1) / `SADC_CLK_NS)
`define SADC_CONV_NS 3000
`define SADC_CONV_CYC (`SADC_CONV_NS / `SADC_CLK_NS)
`define SADC_ACQ_NS 675
`define SADC_ACQ_CYC (`SADC_ACQ_NS / `SADC_CLK_NS)
`define SADC_TRIG_NS 40
`define SADC_TRIG_CYC (`SADC_TRIG_NS / `SADC_CLK_NS)
`define SADC_SCK_MHZ 20
`define SADC_SCK_HALF_CYC (1000 / (2 * `SADC_SCK_MHZ * `SADC_CLK_NS))
`define SADC_MAX_WORDS 2

// =====================================================
// host register map
`define SADC_AXI_AW 8
`define SADC_CTRL_OFS 8'h00
`define SADC_CFG_OFS 8'h04
`define SADC_STAT_OFS 8'h08
`define SADC_DATA0_OFS 8'h0C
`define SADC_DATA1_OFS 8'h10
`define SADC_CTRL_START 0
`define SADC_CFG_CHAIN 0
`define SADC_CFG_TWO 1
`define SADC_CFG_RST 2'h0
`define SADC_ST_RUN 0
`define SADC_ST_DONE 1
`define SADC_ST_POR 2
`define SADC_ST_DEVBUSY 3
`define SADC_RESP_OKAY 2'h0
`define SADC_RESP_DECERR 2'h3

`endif

// ===== verilog/sadc_pkg.sv
// state types of the converter end and the controller end
// assumes nothing beyond the shared defines
package sadc_pkg;
    // =====================================================
    // state machines
    typedef enum logic {
        SADC_DEV_PDN,
        SADC_DEV_CONV
    } sadc_dev_state_e;

    typedef enum logic [2:0] {
        SADC_H_POR,
        SADC_H_IDLE,
        SADC_H_TRIG,
        SADC_H_WBH,
        SADC_H_WBL,
        SADC_H_PRE,
        SADC_H_LOW,
        SADC_H_HIGH
    } sadc_host_state_e;
endpackage : sadc_pkg

// ===== verilog/sadc_if.sv
// link between converter and controller: trigger, busy, shift clock,
// serial data and the read enable / chain input line
// assumes a pull-up holds the data line high when nobody drives it
`timescale 1ns/100ps
interface sadc_if;
    logic conversion_trigger;
    logic busy;
    logic sck;
    logic read_enable_chain_input;
    logic sdo_o;
    logic sdo_oe_n;
    logic sdo;

    // =====================================================
    // resolved data line, pulled high while released
    assign sdo = sdo_oe_n ? 1'b1 : sdo_o;

    modport dev (
        input conversion_trigger, sck, read_enable_chain_input,
        output busy, sdo_o, sdo_oe_n
    );
    modport host (
        output conversion_trigger, sck, read_enable_chain_input,
        input busy, sdo
    );
endinterface : sadc_if

// ===== verilog/sadc_dev.sv
// converter end: conversion timing, auto power-down and serial readout
// assumes link pins and straps are asynchronous; sample_in is on clk
`timescale 1ns/100ps
`include "sadc_defines.svh"

module sadc_dev
    import sadc_pkg::*;
#(
    parameter int unsigned POR_CYC = `SADC_POR_CYC,
    parameter int unsigned CONV_CYC = `SADC_CONV_CYC,
    parameter int unsigned ACQ_CYC = `SADC_ACQ_CYC,
    parameter int unsigned RES_W = `SADC_RES_W
) (
    input wire logic clk, // system clock
    input wire logic rst_n, // async reset
    sadc_if.dev link, // link to the controller
    input wire logic [RES_W-1:0] sample_in, // value held at conversion start
    input wire logic chain_pin, // chain mode strap
    input wire logic supply_ok, // supply above 1V
    output logic powered_up, // converter core awake
    output logic acquiring, // input being tracked
    output logic result_invalid // last result started too early
);

    // =====================================================
    // constants
    localparam int unsigned CW = $clog2(CONV_CYC + 1);
    localparam int unsigned PW = $clog2(POR_CYC + 1);
    localparam int unsigned SY_TRIG = 0;
    localparam int unsigned SY_SCK = 1;
    localparam int unsigned SY_RDL = 2;
    localparam int unsigned SY_CHAIN = 3;
    localparam int unsigned SY_SUP = 4;

    // =====================================================
    // state
    logic [4:0] s1_r, s1_nxt;
    logic [4:0] s2_r, s2_nxt;
    logic trig_d_r, trig_d_nxt;
    logic sck_d_r, sck_d_nxt;
    sadc_dev_state_e state_r, state_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic [PW-1:0] por_cnt_r, por_cnt_nxt;
    logic por_done_r, por_done_nxt;
    logic [RES_W-1:0] held_r, held_nxt;
    logic [RES_W-1:0] shreg_r, shreg_nxt;
    logic busy_r, busy_nxt;
    logic oe_n_r, oe_n_nxt;
    logic early_r, early_nxt;
    logic inval_r, inval_nxt;
    logic acq_r, acq_nxt;
    logic trig_rise;
    logic sck_rise;
    logic load;

    // edges seen only on the second synchroniser stage
    assign trig_rise = s2_r[SY_TRIG] & ~trig_d_r;
    assign sck_rise = s2_r[SY_SCK] & ~sck_d_r;

    // =====================================================
    // next-state logic
    always_comb begin
        s1_nxt = {supply_ok, chain_pin, link.read_enable_chain_input, link.sck, link.conversion_trigger};
        s2_nxt = s1_r;
        trig_d_nxt = s2_r[SY_TRIG];
        sck_d_nxt = s2_r[SY_SCK];
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        por_cnt_nxt = por_cnt_r;
        por_done_nxt = por_done_r;
        held_nxt = held_r;
        shreg_nxt = shreg_r;
        busy_nxt = busy_r;
        early_nxt = early_r;
        inval_nxt = inval_r;
        acq_nxt = acq_r;
        load = 1'b0;
        if (!s2_r[SY_SUP]) begin
            // supply lost: all but the synchronisers, the edge delay flops and the driver enable back to their power-on values
            state_nxt = SADC_DEV_PDN;
            cnt_nxt = '0;
            por_cnt_nxt = '0;
            por_done_nxt = 1'b0;
            held_nxt = '0;
            shreg_nxt = '0;
            busy_nxt = 1'b0;
            early_nxt = 1'b0;
            inval_nxt = 1'b0;
            acq_nxt = 1'b1;
        end else begin
            // reinitialisation period after supply returns
            if (!por_done_r) begin
                por_cnt_nxt = por_cnt_r + PW'(1);
                if (por_cnt_r == PW'(POR_CYC - 1)) begin
                    por_done_nxt = 1'b1;
                end
            end
            case (state_r)
                SADC_DEV_PDN: begin
                    acq_nxt = 1'b1;
                    if (trig_rise) begin
                        // wake up and freeze the tracked input
                        state_nxt = SADC_DEV_CONV;
                        busy_nxt = 1'b1;
                        cnt_nxt = '0;
                        held_nxt = sample_in;
                        acq_nxt = 1'b0;
                        early_nxt = ~por_done_r;
                    end
                end
                SADC_DEV_CONV: begin
                    // trigger edges are not looked at here
                    cnt_nxt = cnt_r + CW'(1);
                    if (cnt_r == CW'(ACQ_CYC - 1)) begin
                        acq_nxt = 1'b1;
                    end
                    if (cnt_r == CW'(CONV_CYC - 1)) begin
                        state_nxt = SADC_DEV_PDN;
                        busy_nxt = 1'b0;
                        shreg_nxt = held_r;
                        inval_nxt = early_r;
                        load = 1'b1;
                    end
                end
                default: begin
                    state_nxt = SADC_DEV_PDN;
                    busy_nxt = 1'b0;
                end
            endcase
            // a new result wins over a shift in the same cycle
            if (sck_rise && !load) begin
                shreg_nxt = {shreg_r[RES_W-2:0], s2_r[SY_CHAIN] & s2_r[SY_RDL]};
            end
        end
        // chain mode drives always, normal mode follows the enable
        if (s2_r[SY_CHAIN]) begin
            oe_n_nxt = 1'b0;
        end else begin
            oe_n_nxt = s2_r[SY_RDL];
        end
    end

    // =====================================================
    // registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= 5'h04; // enable line idles high, so no drive after reset
            s2_r <= 5'h04;
            trig_d_r <= 1'b0;
            sck_d_r <= 1'b0;
            state_r <= SADC_DEV_PDN;
            cnt_r <= '0;
            por_cnt_r <= '0;
            por_done_r <= 1'b0;
            held_r <= '0;
            shreg_r <= '0;
            busy_r <= 1'b0;
            oe_n_r <= 1'b1;
            early_r <= 1'b0;
            inval_r <= 1'b0;
            acq_r <= 1'b1;
        end else begin
            s1_r <= s1_nxt;
            s2_r <= s2_nxt;
            trig_d_r <= trig_d_nxt;
            sck_d_r <= sck_d_nxt;
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            por_cnt_r <= por_cnt_nxt;
            por_done_r <= por_done_nxt;
            held_r <= held_nxt;
            shreg_r <= shreg_nxt;
            busy_r <= busy_nxt;
            oe_n_r <= oe_n_nxt;
            early_r <= early_nxt;
            inval_r <= inval_nxt;
            acq_r <= acq_nxt;
        end
    end

    // =====================================================
    // outputs, all from flip-flops
    assign link.busy = busy_r;
    assign link.sdo_o = shreg_r[RES_W-1];
    assign link.sdo_oe_n = oe_n_r;
    assign powered_up = busy_r;
    assign acquiring = acq_r;
    assign result_invalid = inval_r;

endmodule : sadc_dev

// ===== verilog/sadc_host.sv
// controller end: AXI4-Lite register slave driving conversions and readout
// assumes busy and data come from another domain; AXI is on clk
`timescale 1ns/100ps
`include "sadc_defines.svh"

module sadc_host
    import sadc_pkg::*;
#(
    parameter int unsigned POR_CYC = `SADC_POR_CYC,
    parameter int unsigned TRIG_CYC = `SADC_TRIG_CYC,
    parameter int unsigned HALF_CYC = `SADC_SCK_HALF_CYC,
    parameter int unsigned RES_W = `SADC_RES_W
) (
    input wire logic clk, // system clock
    input wire logic rst_n, // async reset
    sadc_if.host link, // link to the converter
    output logic chain_mode, // strap value for the converter
    input wire logic [`SADC_AXI_AW-1:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // byte strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [`SADC_AXI_AW-1:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready // read data ready
);
    localparam int unsigned DW = `SADC_MAX_WORDS * RES_W;
    localparam int unsigned CW = $clog2(POR_CYC + 1);
    localparam int unsigned BW = $clog2(DW + 1);

    // =====================================================
    // state
    logic [1:0] s1_r, s1_nxt, s2_r, s2_nxt;
    logic aw_h_r, aw_h_nxt, w_h_r, w_h_nxt, bv_r, bv_nxt, rv_r, rv_nxt;
    logic [`SADC_AXI_AW-1:0] awa_r, awa_nxt;
    logic [31:0] wd_r, wd_nxt, rd_r, rd_nxt;
    logic [1:0] br_r, br_nxt, rr_r, rr_nxt;
    logic [1:0] cfg_r, cfg_nxt;
    logic done_r, done_nxt;
    sadc_host_state_e st_r, st_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic [BW-1:0] bit_r, bit_nxt;
    logic [DW-1:0] data_r, data_nxt;
    logic trig_r, trig_nxt, sck_r, sck_nxt, rdl_r, rdl_nxt;
    logic wr, start, run;
    logic [31:0] d0, d1;

    // words as they sit in the capture register
    assign d0 = cfg_r[`SADC_CFG_TWO] ? 32'(data_r[DW-1:RES_W]) : 32'(data_r[RES_W-1:0]);
    assign d1 = cfg_r[`SADC_CFG_TWO] ? 32'(data_r[RES_W-1:0]) : 32'h00000000;
    assign run = (st_r != SADC_H_IDLE) && (st_r != SADC_H_POR);
    assign wr = aw_h_r & w_h_r;
    assign start = wr && awa_r == `SADC_CTRL_OFS && s_axi_wstrb_ok(wd_r) && !run && st_r == SADC_H_IDLE;

    // start bit only, byte strobe 0 is checked when the data is taken
    function automatic logic s_axi_wstrb_ok(input logic [31:0] d);
        return d[`SADC_CTRL_START];
    endfunction : s_axi_wstrb_ok

    // =====================================================
    // bus slave and readout engine
    always_comb begin
        s1_nxt = {link.sdo, link.busy};
        s2_nxt = s1_r;
        aw_h_nxt = aw_h_r;
        w_h_nxt = w_h_r;
        awa_nxt = awa_r;
        wd_nxt = wd_r;
        bv_nxt = bv_r;
        br_nxt = br_r;
        rv_nxt = rv_r;
        rd_nxt = rd_r;
        rr_nxt = rr_r;
        cfg_nxt = cfg_r;
        done_nxt = done_r;
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        bit_nxt = bit_r;
        data_nxt = data_r;
        trig_nxt = trig_r;
        sck_nxt = sck_r;
        rdl_nxt = rdl_r;
        // address and data taken in either order, one write at a time
        if (s_axi_awvalid && s_axi_awready) begin
            aw_h_nxt = 1'b1;
            awa_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_h_nxt = 1'b1;
            wd_nxt = s_axi_wstrb[0] ? s_axi_wdata : 32'h00000000;
        end
        if (wr) begin
            aw_h_nxt = 1'b0;
            w_h_nxt = 1'b0;
            bv_nxt = 1'b1;
            br_nxt = `SADC_RESP_OKAY;
            case (awa_r)
                `SADC_CTRL_OFS, `SADC_DATA0_OFS, `SADC_DATA1_OFS: ;
                `SADC_CFG_OFS: if (!run) cfg_nxt = wd_r[1:0];
                `SADC_STAT_OFS: if (wd_r[`SADC_ST_DONE]) done_nxt = 1'b0;
                default: br_nxt = `SADC_RESP_DECERR;
            endcase
        end else if (bv_r && s_axi_bready) begin
            bv_nxt = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rv_nxt = 1'b1;
            rr_nxt = `SADC_RESP_OKAY;
            case (s_axi_araddr)
                `SADC_CTRL_OFS: rd_nxt = 32'h00000000;
                `SADC_CFG_OFS: rd_nxt = {30'h00000000, cfg_r};
                `SADC_STAT_OFS: rd_nxt = {28'h0000000, s2_r[0], ~(st_r == SADC_H_POR), done_r, run};
                `SADC_DATA0_OFS: rd_nxt = d0;
                `SADC_DATA1_OFS: rd_nxt = d1;
                default: begin
                    rd_nxt = 32'h00000000;
                    rr_nxt = `SADC_RESP_DECERR;
                end
            endcase
        end else if (rv_r && s_axi_rready) begin
            rv_nxt = 1'b0;
        end
        // readout sequence
        case (st_r)
            SADC_H_POR: begin
                cnt_nxt = cnt_r + CW'(1);
                if (cnt_r == CW'(POR_CYC - 1)) st_nxt = SADC_H_IDLE;
            end
            SADC_H_IDLE: if (start) begin
                st_nxt = SADC_H_TRIG;
                trig_nxt = 1'b1;
                cnt_nxt = '0;
            end
            SADC_H_TRIG: begin
                cnt_nxt = cnt_r + CW'(1);
                if (cnt_r == CW'(TRIG_CYC - 1)) begin
                    trig_nxt = 1'b0;
                    st_nxt = SADC_H_WBH;
                end
            end
            SADC_H_WBH: if (s2_r[0]) st_nxt = SADC_H_WBL;
            SADC_H_WBL: if (!s2_r[0]) begin
                rdl_nxt = 1'b0;
                cnt_nxt = '0;
                st_nxt = SADC_H_PRE;
            end
            SADC_H_PRE: begin
                cnt_nxt = cnt_r + CW'(1);
                if (cnt_r == CW'(HALF_CYC - 1)) begin
                    cnt_nxt = '0;
                    bit_nxt = '0;
                    st_nxt = SADC_H_LOW;
                end
            end
            SADC_H_LOW: begin
                cnt_nxt = cnt_r + CW'(1);
                if (cnt_r == CW'(HALF_CYC - 1)) begin
                    cnt_nxt = '0;
                    data_nxt = {data_r[DW-2:0], s2_r[1]};
                    if (bit_r == BW'(cfg_r[`SADC_CFG_TWO] ? DW - 1 : RES_W - 1)) begin
                        rdl_nxt = ~cfg_r[`SADC_CFG_CHAIN];
                        done_nxt = 1'b1;
                        st_nxt = SADC_H_IDLE;
                    end else begin
                        sck_nxt = 1'b1;
                        st_nxt = SADC_H_HIGH;
                    end
                end
            end
            SADC_H_HIGH: begin
                cnt_nxt = cnt_r + CW'(1);
                if (cnt_r == CW'(HALF_CYC - 1)) begin
                    cnt_nxt = '0;
                    sck_nxt = 1'b0;
                    bit_nxt = bit_r + BW'(1);
                    st_nxt = SADC_H_LOW;
                end
            end
            default: st_nxt = SADC_H_IDLE;
        endcase
        // chain mode feeds zeros into the first converter
        // follows the next strap value so line and strap switch on one edge, except when chain mode is left during SADC_H_POR
        if (cfg_nxt[`SADC_CFG_CHAIN]) rdl_nxt = 1'b0;
        else if (st_r == SADC_H_IDLE) rdl_nxt = 1'b1;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= 2'h0;
            s2_r <= 2'h0;
            aw_h_r <= 1'b0;
            w_h_r <= 1'b0;
            awa_r <= '0;
            wd_r <= 32'h00000000;
            bv_r <= 1'b0;
            br_r <= 2'h0;
            rv_r <= 1'b0;
            rd_r <= 32'h00000000;
            rr_r <= 2'h0;
            cfg_r <= `SADC_CFG_RST;
            done_r <= 1'b0;
            st_r <= SADC_H_POR;
            cnt_r <= '0;
            bit_r <= '0;
            data_r <= '0;
            trig_r <= 1'b0;
            sck_r <= 1'b0;
            rdl_r <= 1'b1;
        end else begin
            s1_r <= s1_nxt;
            s2_r <= s2_nxt;
            aw_h_r <= aw_h_nxt;
            w_h_r <= w_h_nxt;
            awa_r <= awa_nxt;
            wd_r <= wd_nxt;
            bv_r <= bv_nxt;
            br_r <= br_nxt;
            rv_r <= rv_nxt;
            rd_r <= rd_nxt;
            rr_r <= rr_nxt;
            cfg_r <= cfg_nxt;
            done_r <= done_nxt;
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            bit_r <= bit_nxt;
            data_r <= data_nxt;
            trig_r <= trig_nxt;
            sck_r <= sck_nxt;
            rdl_r <= rdl_nxt;
        end
    end

    // =====================================================
    // outputs
    assign s_axi_awready = ~aw_h_r & ~bv_r;
    assign s_axi_wready = ~w_h_r & ~bv_r;
    assign s_axi_bvalid = bv_r;
    assign s_axi_bresp = br_r;
    assign s_axi_arready = ~rv_r;
    assign s_axi_rvalid = rv_r;
    assign s_axi_rdata = rd_r;
    assign s_axi_rresp = rr_r;
    assign link.conversion_trigger = trig_r;
    assign link.sck = sck_r;
    assign link.read_enable_chain_input = rdl_r;
    assign chain_mode = cfg_r[`SADC_CFG_CHAIN];

endmodule : sadc_host

// ===== tb/sadc_asserts.sv
// checker on the link between converter and controller
// assumes one clock domain; placed beside the link interface
`timescale 1ns/100ps
module sadc_asserts #(
    parameter int unsigned CONV_CYC = 600
) (
    input wire logic clk, // system clock
    input wire logic rst_n, // async reset
    input wire logic conversion_trigger, // start edge
    input wire logic busy, // converting
    input wire logic sck, // shift clock
    input wire logic read_enable_chain_input, // enable or chain data
    input wire logic sdo_o, // data bit
    input wire logic sdo_oe_n, // low = driving
    input wire logic sdo // resolved line
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    // =========
    // busy length counter, read at the fall
    logic [10:0] bcnt_r;
    logic [10:0] bcnt_nxt;
    always_comb begin
        bcnt_nxt = busy ? bcnt_r + 11'h001 : 11'h000;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bcnt_r <= 11'h000;
        end else begin
            bcnt_r <= bcnt_nxt;
        end
    end

    // =========
    // link timing
    a_busy_cause: assert property ($rose(busy) |-> $past(conversion_trigger, 3))
        else $error("busy rose without trigger");
    a_busy_length: assert property ($fell(busy) |-> bcnt_r >= CONV_CYC - 1 && bcnt_r <= CONV_CYC + 1)
        else $error("conversion length off");
    a_sdo_moves: assert property ($changed(sdo_o) |-> $fell(busy) || $past(sck, 3) && !$past(sck, 4))
        else $error("data moved without cause");
    a_oe_on: assert property ($fell(sdo_oe_n) |-> !$past(read_enable_chain_input, 3))
        else $error("drive without enable");
    a_oe_off: assert property ($rose(sdo_oe_n) |-> $past(read_enable_chain_input, 3))
        else $error("release without enable high");
    a_read_after: assert property (busy |-> !sck)
        else $error("shift clock during conversion");
    a_sck_half: assert property ($rose(sck) |-> sck [*5] ##1 !sck)
        else $error("shift clock half period off");
    a_trig_width: assert property ($rose(conversion_trigger) |-> conversion_trigger [*8] ##1 !conversion_trigger)
        else $error("trigger width off");
    a_select_gap: assert property ($fell(read_enable_chain_input) |-> !busy)
        else $error("enable lowered during conversion");

    c_conv: cover property ($fell(busy));
    c_select: cover property ($fell(sdo_oe_n));
    c_shift: cover property ($rose(sck) && !sdo);
endmodule : sadc_asserts

// ===== tb/sar_adc_conversion_serial_readout_bench.sv
// bench: both link ends, an AXI4-Lite master, supply and sample stimulus
// assumes the design files and the checker compile first
`timescale 1ns/100ps
`include "sadc_defines.svh"
module sar_adc_conversion_serial_readout_bench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic supply_ok = 1'b1;
    logic [19:0] sample = 20'h00000;
    logic chain;
    logic pu;
    logic acq;
    logic inval;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h00000000;
    logic [31:0] rdata;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    int bad_count = 0;
    int check_count = 0;
    int rises = 0;
    int gap = 0;
    logic [39:0] cap = 40'h0000000000;
    sadc_if link();

    sadc_dev #(.POR_CYC(50)) sadc_dev_inst (.clk(clk), .rst_n(rst_n), .link(link), .sample_in(sample),
        .chain_pin(chain), .supply_ok(supply_ok), .powered_up(pu), .acquiring(acq), .result_invalid(inval));
    sadc_host #(.POR_CYC(50)) sadc_host_inst (.clk(clk), .rst_n(rst_n), .link(link), .chain_mode(chain),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    sadc_asserts #(.CONV_CYC(`SADC_CONV_CYC)) sadc_asserts_inst (.clk(clk), .rst_n(rst_n),
        .conversion_trigger(link.conversion_trigger), .busy(link.busy), .sck(link.sck),
        .read_enable_chain_input(link.read_enable_chain_input), .sdo_o(link.sdo_o),
        .sdo_oe_n(link.sdo_oe_n), .sdo(link.sdo));

    initial begin
        forever #2.5 clk = ~clk;
    end

    // wire monitor: line level just before each shift edge, starts, acquisition gap
    always @(posedge clk) begin
        if ($rose(link.sck)) cap <= {cap[38:0], link.sdo};
        if ($rose(link.busy)) rises <= rises + 1;
        if (!acq) gap <= $fell(acq) ? 1 : gap + 1;
    end

    // =========
    // tasks
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", n, e, s);
        end
    endtask : chk

    // valids drop as each channel is taken; response waited for
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (bvalid !== 1'b1) begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end
        chk("bresp", 32'(bresp), 32'(er));
        bready <= 1'b0;
        @(posedge clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (rvalid !== 1'b1) begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge clk);
    endtask : rd

    // one conversion and readout; a second start while running must be dropped
    task automatic conv(input logic [19:0] s, input logic [1:0] cfg, input logic bad);
        logic [31:0] d;
        logic [1:0] r;
        int n0;
        n0 = rises;
        sample <= s;
        wr(`SADC_CFG_OFS, {30'h0, cfg}, `SADC_RESP_OKAY);
        wr(`SADC_CTRL_OFS, 32'h1, `SADC_RESP_OKAY);
        wr(`SADC_CTRL_OFS, 32'h1, `SADC_RESP_OKAY);
        d = 32'h0;
        while (d[1] !== 1'b1) rd(`SADC_STAT_OFS, d, r);
        chk("starts", 32'(rises - n0), 32'h1);
        rd(`SADC_DATA0_OFS, d, r);
        chk("data0", d, {12'h000, s});
        rd(`SADC_DATA1_OFS, d, r);
        chk("data1", d, 32'h0);
        // one rise fewer than bits: the last bit of a single word still stands on the driver
        chk("wire", 32'(cfg[1] ? cap[38:19] : {cap[18:0], link.sdo_o}), {12'h000, s});
        chk("powered", 32'(pu), 32'h0);
        chk("invalid", 32'(inval), 32'(bad));
        chk("acq_gap", 32'(gap >= 134 && gap <= 136), 32'h1);
        chk("oe_n", 32'(link.sdo_oe_n), 32'(!cfg[0]));
        wr(`SADC_STAT_OFS, 32'h2, `SADC_RESP_OKAY);
    endtask : conv

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test

    // =========
    // main sequence and watchdog
    initial begin
        #400000;
        bad_count++;
        end_of_test();
    end

    initial begin
        logic [31:0] d;
        logic [1:0] r;
        void'($urandom(75185));
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        wr(`SADC_CTRL_OFS, 32'h1, `SADC_RESP_OKAY);
        rd(`SADC_STAT_OFS, d, r);
        chk("por_stat", d, 32'h0);
        rd(`SADC_CFG_OFS, d, r);
        chk("cfg_rst", d, 32'(`SADC_CFG_RST));
        rd(8'h40, d, r);
        chk("unmapped", {d[29:0], r}, 32'h3);
        wr(8'h40, 32'h0, `SADC_RESP_DECERR);
        repeat (60) @(posedge clk);
        chk("busy_idle", 32'(link.busy), 32'h0);
        $display("test reset done");
        // supply loss, then a start inside the recovery span
        supply_ok <= 1'b0;
        repeat (5) @(posedge clk);
        supply_ok <= 1'b1;
        conv(20'hFFFFF, 2'b00, 1'b1);
        $display("test supply done");
        for (int i = 0; i < 8; i++) begin
            conv(i < 4 ? 20'(i * 20'h55555) : 20'($urandom()), 2'(i < 4 ? i : $urandom()), 1'b0);
            $display("test %0d done", i);
        end
        end_of_test();
    end
endmodule : sar_adc_conversion_serial_readout_bench
